// ==== tb/lhf_host_model.sv ====
// Purpose: Host model that writes and reads the limp-home bank
// Assumes: Bank samples strobes on the rising edge of ref_clk_in
// Notes:   Released lines carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none

module lhf_host_model (
    // Clock
    input  wire logic       ref_clk_in,
    // Register port toward the bank
    output var  logic [7:0] reg_addr_out,
    output var  logic [7:0] reg_wdata_out,
    output var  logic       reg_wr_out,
    output var  logic       reg_rd_out,
    output var  logic [1:0] enable_write_out,
    input  wire logic [7:0] reg_rdata_in
);
    // Idle levels at time zero
    initial begin
        reg_addr_out     = 8'h00;
        reg_wdata_out    = 8'h00;
        reg_wr_out       = 1'b0;
        reg_rd_out       = 1'b0;
        enable_write_out = 2'b00;
    end

    // One write; all fields held until the taking edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(posedge ref_clk_in);
        #1;
        reg_wr_out    = 1'b0;
        // Stale data must not look like a valid value
        reg_addr_out  = ~a;
        reg_wdata_out = ~d;
    endtask

    // One read; data is taken after the answer has landed
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(posedge ref_clk_in);
        #1;
        reg_rd_out   = 1'b0;
        reg_addr_out = ~a;
        @(posedge ref_clk_in);
        #1;
        d = reg_rdata_in;
    endtask

    // Host rewrites a channel enable bit to one
    task automatic reenable(input int ch);
        @(posedge ref_clk_in);
        #1;
        enable_write_out[ch] = 1'b1;
        @(posedge ref_clk_in);
        #1;
        enable_write_out[ch] = 1'b0;
    endtask
endmodule // lhf_host_model

`default_nettype wire

// ==== tb/test_limp_home_fault_config_regs.sv ====
// Purpose: Self-checking bench for the limp-home fault register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Channel ticks run every cycle so timers count clock cycles
`timescale 1ns/1ps
`default_nettype none

module test_limp_home_fault_config_regs;
    import lhf_pkg::*;
    // Clock, reset and context inputs
    logic        clk, rst, lh, tp, vmode, por_clr;
    logic [1:0]  ss_act, tick;
    lhf_faults_t flt;
    // Host port nets
    logic [7:0]  addr, wdata, rdata, rd_val;
    logic        wr, rd;
    logic [1:0]  en_wr;
    // Observed outputs
    logic [1:0]  pin, oe, off, expd;
    logic [5:0]  ov_code, trim_code;
    logic        por, srst;
    int          n_errors = 0;
    int          check_count = 0;
    // Reset values of 20h..27h; 26h and unmapped 27h read zero
    logic [7:0]  defv [8] = '{8'h99, 8'h3c, 8'h0f, 8'h00,
                              8'h22, 8'h00, 8'h00, 8'h00};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    lhf_host_model host_u (.ref_clk_in(clk), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
        .enable_write_out(en_wr), .reg_rdata_in(rdata));

    lhf_regs dut_u (.ref_clk_in(clk), .sys_rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .limp_home_pin_in(lh),
        .two_phase_select_in(tp), .voltage_mode_in(vmode),
        .softstart_active_in(ss_act), .ch_tick_in(tick),
        .channel_enable_write_in(en_wr), .power_on_clear_in(por_clr),
        .faults_in(flt), .fault_pin_out(pin), .fault_pin_oe_out(oe),
        .channel_off_out(off), .timer_expired_out(expd),
        .overvoltage_threshold_code_out(ov_code),
        .sense_offset_code_out(trim_code),
        .power_on_indicator_out(por), .soft_reset_out(srst));

    // Verdict; the single exit of the run
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Register-width results
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Per-channel flag pairs
    task automatic check_out(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.read_reg(a, rd_val);
        check_reg(rd_val, exp);
    endtask

    // Drives the channel timers set in f and samples expiry at given counts
    task automatic timer_run(input logic [1:0] f, input logic [1:0] e1,
                             input logic [1:0] e2);
        flt.iso = f;
        cycles(990);
        check_out(expd, 2'b00);
        cycles(20);
        check_out(expd, e1);
        cycles(480);
        check_out(expd, e1);
        cycles(20);
        check_out(expd, e2);
        flt.iso = 2'b00;
        cycles(4);
    endtask

    initial begin
        rst = 1'b1; lh = 1'b1; tp = 1'b0; vmode = 1'b0; por_clr = 1'b0;
        ss_act = 2'b00; tick = 2'b11; flt = '0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        // Defaults of every register, soft-reset and unmapped places
        for (int i = 0; i < 8; i++) rd_chk(8'h20 + i[7:0], defv[i]);
        check_reg({7'h00, por}, 8'h01);
        $display("test reset_values finished");
        // Reserved bits, code outputs and force-off
        host_u.write_reg(8'h22, 8'hff);
        rd_chk(8'h22, 8'h3f);
        host_u.write_reg(8'h24, 8'hff);
        rd_chk(8'h24, 8'h77);
        check_reg({2'b00, ov_code}, 8'h3f);
        host_u.write_reg(8'h25, 8'ha2);
        cycles(3);
        check_reg({2'b00, trim_code}, 8'h29);
        check_out(off, 2'b00);
        check_out(pin, 2'b00);
        host_u.write_reg(8'h25, 8'h11);
        cycles(3);
        check_out(off, 2'b11);
        host_u.write_reg(8'h26, 8'hff);
        rd_chk(8'h26, 8'h00);
        $display("test fields finished");
        // Soft reset keeps the cleared power-on flag
        @(posedge clk);
        #1;
        por_clr = 1'b1;
        cycles(1);
        por_clr = 1'b0;
        host_u.write_reg(8'h26, 8'h55);
        rd_chk(8'h24, 8'h77);
        host_u.write_reg(8'h26, 8'hc3);
        check_out({1'b0, srst}, 2'b01);
        for (int i = 0; i < 6; i++) rd_chk(8'h20 + i[7:0], defv[i]);
        check_out({1'b0, por}, 2'b00);
        check_out(off, 2'b00);
        $display("test soft_reset finished");
        // Enable, limp-home pin, soft-start gating, two-phase
        flt.uv = 2'b01;
        cycles(3);
        check_out(oe, 2'b00);
        flt.uv = 2'b00;
        lh = 1'b0;
        flt.ov = 2'b01;
        cycles(3);
        check_out(oe, 2'b00);
        lh = 1'b1;
        cycles(3);
        check_out(oe, 2'b01);
        flt.ov = 2'b00;
        ss_act = 2'b01;
        host_u.write_reg(8'h21, 8'h3d);
        flt.uv = 2'b01;
        cycles(3);
        check_out(oe, 2'b00);
        flt.uv = 2'b00;
        vmode = 1'b1;
        flt.ilim = 2'b01;
        cycles(3);
        check_out(oe, 2'b00);
        vmode = 1'b0;
        cycles(3);
        check_out(oe, 2'b01);
        flt.ilim = 2'b00;
        flt.uv = 2'b01;
        host_u.write_reg(8'h21, 8'h7d);
        cycles(3);
        check_out(oe, 2'b01);
        flt.uv = 2'b00;
        ss_act = 2'b00;
        host_u.write_reg(8'h21, 8'h3f);
        tp = 1'b1;
        flt.ov = 2'b10;
        cycles(3);
        check_out(oe, 2'b00);
        flt.ov = 2'b00;
        tp = 1'b0;
        $display("test fault_enables finished");
        // Latched overvoltage holds channel one off until re-enabled
        host_u.write_reg(8'h23, 8'h04);
        flt.ov = 2'b01;
        cycles(2);
        flt.ov = 2'b00;
        cycles(6);
        check_out(off, 2'b01);
        host_u.reenable(0);
        cycles(3);
        check_out(off, 2'b00);
        $display("test latch finished");
        // Timers: ch1 code 1 of 1000, ch2 code 2 of 1500
        host_u.write_reg(8'h20, 8'h21);
        timer_run(2'b11, 2'b01, 2'b11);
        host_u.write_reg(8'h20, 8'h00);
        timer_run(2'b11, 2'b00, 2'b00);
        host_u.write_reg(8'h20, 8'h01);
        tp = 1'b1;
        timer_run(2'b01, 2'b11, 2'b11);
        tp = 1'b0;
        $display("test timers finished");
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule // test_limp_home_fault_config_regs

`default_nettype wire

// ==== verilog/lhf_consts.svh ====
// Purpose: Named offsets, reset values, field positions and counts
// Assumes: Included by lhf_pkg and the register bank
// Notes:   Definitions only
`ifndef LHF_CONSTS_SVH
`define LHF_CONSTS_SVH

// Register offsets
`define LHF_ADDR_MFT      8'h20
`define LHF_ADDR_FEN_A    8'h21
`define LHF_ADDR_FEN_B    8'h22
`define LHF_ADDR_LATCH    8'h23
`define LHF_ADDR_OVTHR    8'h24
`define LHF_ADDR_TRIM     8'h25
`define LHF_ADDR_SRST     8'h26

// Reset values
`define LHF_RST_MFT       8'h99
`define LHF_RST_FEN_A     8'h3c
`define LHF_RST_FEN_B     8'h0f
`define LHF_RST_LATCH     8'h00
`define LHF_RST_OVTHR     8'h22
`define LHF_RST_TRIM      8'h00

// Writable-bit masks, soft-reset key and zero value; reserved bits stay zero
`define LHF_MASK_FEN_B    8'h3f
`define LHF_MASK_OVTHR    8'h77
`define LHF_SRST_KEY      8'hc3
`define LHF_ZERO8         8'h00

// Field positions (channel 1 bit; channel 2 is one above, except force-off at bit 4)
`define LHF_BIT_RF        6
`define LHF_BIT_FBO       4
`define LHF_BIT_OV        2
`define LHF_BIT_UV        0
`define LHF_BIT_OC        4
`define LHF_BIT_ILIM      2
`define LHF_BIT_ISO       0
`define LHF_BIT_FL_ILIM   6
`define LHF_BIT_FL_OC     4
`define LHF_BIT_FL_OV     2
`define LHF_BIT_FL_UV     0
`define LHF_BIT_OFF1      0
`define LHF_BIT_OFF2      4

// Main fault timer maximum counts per code
`define LHF_MFT_C0        14'h0000
`define LHF_MFT_C1        14'h03e8
`define LHF_MFT_C2        14'h05dc
`define LHF_MFT_C3        14'h07d0
`define LHF_MFT_C4        14'h09c4
`define LHF_MFT_C5        14'h0bb8
`define LHF_MFT_C6        14'h0dac
`define LHF_MFT_C7        14'h0fa0
`define LHF_MFT_C8        14'h1388
`define LHF_MFT_C9        14'h1770
`define LHF_MFT_CA        14'h1b58
`define LHF_MFT_CB        14'h1f40
`define LHF_MFT_CC        14'h2710
`define LHF_MFT_CD        14'h2ee0
`define LHF_MFT_CE        14'h36b0
`define LHF_MFT_CF        14'h3fff
`define LHF_CNT_ONE       14'h0001

`endif

// ==== verilog/lhf_pkg.sv ====
// Purpose: Types shared by the limp-home fault configuration bank
// Assumes: Constants come from lhf_consts.svh
// Notes:   Whole module state is one packed struct
`include "lhf_consts.svh"
package lhf_pkg;
    // Per-channel fault event group
    typedef struct packed {
        logic [1:0] uv;
        logic [1:0] ov;
        logic [1:0] oc;
        logic [1:0] ilim;
        logic [1:0] fbo;
        logic [1:0] iso;
    } lhf_faults_t;

    // All registered state of the bank
    typedef struct packed {
        logic [7:0]  mft_code;
        logic [7:0]  fen_a;
        logic [7:0]  fen_b;
        logic [7:0]  latch_sel;
        logic [7:0]  ov_thr;
        logic [7:0]  trim;
        logic [7:0]  rdata;
        logic [1:0]  latch_off;
        logic [1:0]  expired;
        logic [13:0] cnt1;
        logic [13:0] cnt2;
        logic [1:0]  fault_oe;
        logic [1:0]  chan_off;
        logic        por;
        logic        srst;
    } lhf_state_t;
endpackage : lhf_pkg

// ==== verilog/lhf_regs.sv ====
// Purpose: Limp-home fault configuration registers and main fault timers
// Assumes: Host register port is synchronous to ref_clk_in
// Notes:   Channel clocks arrive as one-cycle ticks on ch_tick_in
//
// What this block does
// - Timer code picks max count, zero disables
// - Fourteen-bit main timer on channel clock
// - Two-phase uses timer one for both
// - Limp-home settings act only while pin high
// - Disabled faults never reach fault pin
// - Enable register A at 21h, reset 3ch
// - Gating off masks undervoltage, voltage-mode limit
// - Gating on keeps faults active in soft-start
// - Feedback-open enable arms detection, no status
// - Channel two OV/UV off in two-phase
// - Enable register B at 22h, reset 0fh
// - Latched fault holds channel off until re-enable
// - Latch select at 23h, reset zero
// - Threshold codes per channel at 24h
// - Two-phase applies only channel-one enable and latch fields
// - Sense trim codes at 25h, reset zero
// - Force-off bit disables its channel
// - Key C3h at 26h restores defaults
// - Soft-reset register reads as zero
// - Soft reset keeps power-on indicator
`timescale 1ns/1ps
`default_nettype none
`include "lhf_consts.svh"

module lhf_regs
    import lhf_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // Host register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // Device context
    input  wire logic        limp_home_pin_in,
    input  wire logic        two_phase_select_in,
    input  wire logic        voltage_mode_in,
    input  wire logic [1:0]  softstart_active_in,
    input  wire logic [1:0]  ch_tick_in,
    input  wire logic [1:0]  channel_enable_write_in,
    input  wire logic        power_on_clear_in,
    input  wire lhf_faults_t faults_in,
    // Fault and channel control outputs
    output logic      [1:0]  fault_pin_out,
    output logic      [1:0]  fault_pin_oe_out,
    output logic      [1:0]  channel_off_out,
    output logic      [1:0]  timer_expired_out,
    output logic      [5:0]  overvoltage_threshold_code_out,
    output logic      [5:0]  sense_offset_code_out,
    output logic             power_on_indicator_out,
    output logic             soft_reset_out
);

    lhf_state_t st_reg;                 // Registered state
    lhf_state_t st_next;                // Next state

    // Code to maximum count lookup
    function automatic logic [13:0] mft_max(input logic [3:0] code);
        case (code)
            4'h0:    mft_max = `LHF_MFT_C0;
            4'h1:    mft_max = `LHF_MFT_C1;
            4'h2:    mft_max = `LHF_MFT_C2;
            4'h3:    mft_max = `LHF_MFT_C3;
            4'h4:    mft_max = `LHF_MFT_C4;
            4'h5:    mft_max = `LHF_MFT_C5;
            4'h6:    mft_max = `LHF_MFT_C6;
            4'h7:    mft_max = `LHF_MFT_C7;
            4'h8:    mft_max = `LHF_MFT_C8;
            4'h9:    mft_max = `LHF_MFT_C9;
            4'ha:    mft_max = `LHF_MFT_CA;
            4'hb:    mft_max = `LHF_MFT_CB;
            4'hc:    mft_max = `LHF_MFT_CC;
            4'hd:    mft_max = `LHF_MFT_CD;
            4'he:    mft_max = `LHF_MFT_CE;
            default: mft_max = `LHF_MFT_CF;
        endcase
    endfunction

    // Pick a channel's field bit; two-phase always takes channel one
    function automatic logic pick(input logic [7:0] r, input int pos,
                                  input int ch, input logic tp);
        pick = tp ? r[pos] : r[pos + ch];
    endfunction

    logic       lh;                     // Limp-home settings in force
    logic       tp;                     // Two-phase selected
    logic [1:0] uv_e;                   // Effective fault terms
    logic [1:0] ov_e;
    logic [1:0] oc_e;
    logic [1:0] il_e;
    logic [1:0] fb_e;
    logic [1:0] is_e;
    logic [1:0] any_f;                  // Any enabled fault per channel
    logic [1:0] lat_f;                  // Fault that is configured latched
    logic [1:0] tmr_run;                // Timer count condition
    logic [1:0] force_off;              // Force-off bits
    logic [13:0] max1;                  // Channel-one terminal count
    logic [13:0] max2;                  // Channel-two terminal count
    logic       wr_srst;                // Valid soft-reset write
    logic [7:0] rd_val;                 // Read mux

    // Fault qualification, read mux and timer conditions
    always_comb begin
        lh = limp_home_pin_in;
        tp = two_phase_select_in;
        for (int c = 0; c < 2; c++) begin
            logic rf;
            logic ss;
            rf = pick(st_reg.fen_a, `LHF_BIT_RF, c, tp);
            ss = softstart_active_in[c];
            // Gating low hides undervoltage during soft start
            uv_e[c] = lh & faults_in.uv[c]
                    & pick(st_reg.fen_a, `LHF_BIT_UV, c, tp)
                    & (rf | ~ss);
            ov_e[c] = lh & faults_in.ov[c]
                    & pick(st_reg.fen_a, `LHF_BIT_OV, c, tp);
            fb_e[c] = lh & faults_in.fbo[c]
                    & pick(st_reg.fen_a, `LHF_BIT_FBO, c, tp);
            oc_e[c] = lh & faults_in.oc[c]
                    & pick(st_reg.fen_b, `LHF_BIT_OC, c, tp);
            // Gating low also hides the current-limit fault during soft start in voltage mode
            il_e[c] = lh & faults_in.ilim[c]
                    & pick(st_reg.fen_b, `LHF_BIT_ILIM, c, tp)
                    & ~(~rf & ss & voltage_mode_in);
            is_e[c] = lh & faults_in.iso[c]
                    & pick(st_reg.fen_b, `LHF_BIT_ISO, c, tp);
            lat_f[c] = (uv_e[c] & pick(st_reg.latch_sel,
                                       `LHF_BIT_FL_UV, c, tp))
                     | (ov_e[c] & pick(st_reg.latch_sel,
                                       `LHF_BIT_FL_OV, c, tp))
                     | (oc_e[c] & pick(st_reg.latch_sel,
                                       `LHF_BIT_FL_OC, c, tp))
                     | (il_e[c] & pick(st_reg.latch_sel,
                                       `LHF_BIT_FL_ILIM, c, tp));
        end
        // Channel two OV/UV have no meaning in two-phase
        if (tp) begin
            uv_e[1] = 1'b0;
            ov_e[1] = 1'b0;
        end
        any_f = uv_e | ov_e | oc_e | il_e | fb_e | is_e;
        if (tp) begin
            lat_f[1] = lat_f[0] | (oc_e[1] & st_reg.latch_sel[`LHF_BIT_FL_OC])
                     | (il_e[1] & st_reg.latch_sel[`LHF_BIT_FL_ILIM]);
        end
        force_off[0] = st_reg.trim[`LHF_BIT_OFF1];
        force_off[1] = st_reg.trim[`LHF_BIT_OFF2];
        // Two-phase feeds both channels into timer one
        max1 = lh ? mft_max(st_reg.mft_code[3:0]) : `LHF_MFT_C0;
        max2 = (lh & ~tp) ? mft_max(st_reg.mft_code[7:4]) : `LHF_MFT_C0;
        tmr_run[0] = tp ? (any_f[0] | any_f[1]) : any_f[0];
        tmr_run[1] = any_f[1] & ~tp;
        wr_srst = reg_wr_in & (reg_addr_in == `LHF_ADDR_SRST)
                & (reg_wdata_in == `LHF_SRST_KEY);
        case (reg_addr_in)
            `LHF_ADDR_MFT:    rd_val = st_reg.mft_code;
            `LHF_ADDR_FEN_A:  rd_val = st_reg.fen_a;
            `LHF_ADDR_FEN_B:  rd_val = st_reg.fen_b;
            `LHF_ADDR_LATCH:  rd_val = st_reg.latch_sel;
            `LHF_ADDR_OVTHR:  rd_val = st_reg.ov_thr;
            `LHF_ADDR_TRIM:   rd_val = st_reg.trim;
            `LHF_ADDR_SRST:   rd_val = `LHF_ZERO8;
            default:          rd_val = `LHF_ZERO8;
        endcase
    end

    // Next-state: register writes, timers, latches and outputs
    always_comb begin
        st_next = st_reg;
        st_next.srst = wr_srst;
        if (reg_rd_in) begin
            st_next.rdata = rd_val;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                `LHF_ADDR_MFT:   st_next.mft_code = reg_wdata_in;
                `LHF_ADDR_FEN_A: st_next.fen_a = reg_wdata_in;
                `LHF_ADDR_FEN_B: st_next.fen_b =
                                     reg_wdata_in & `LHF_MASK_FEN_B;
                `LHF_ADDR_LATCH: st_next.latch_sel = reg_wdata_in;
                `LHF_ADDR_OVTHR: st_next.ov_thr =
                                     reg_wdata_in & `LHF_MASK_OVTHR;
                `LHF_ADDR_TRIM:  st_next.trim = reg_wdata_in;
                default:         st_next.srst = wr_srst;
            endcase
        end
        // Key write restores defaults; indicator is deliberately kept
        if (wr_srst) begin
            st_next.mft_code  = `LHF_RST_MFT;
            st_next.fen_a     = `LHF_RST_FEN_A;
            st_next.fen_b     = `LHF_RST_FEN_B;
            st_next.latch_sel = `LHF_RST_LATCH;
            st_next.ov_thr    = `LHF_RST_OVTHR;
            st_next.trim      = `LHF_RST_TRIM;
        end
        if (power_on_clear_in) begin
            st_next.por = 1'b0;
        end
        // Timer one; counts channel ticks while a fault persists
        if (!tmr_run[0] || max1 == `LHF_MFT_C0) begin
            st_next.cnt1    = `LHF_MFT_C0;
            st_next.expired[0] = 1'b0;
        end else if (st_reg.cnt1 >= max1) begin
            st_next.expired[0] = 1'b1;
        end else if (ch_tick_in[0]) begin
            st_next.cnt1 = st_reg.cnt1 + `LHF_CNT_ONE;
        end
        // Timer two idles in two-phase
        if (!tmr_run[1] || max2 == `LHF_MFT_C0) begin
            st_next.cnt2    = `LHF_MFT_C0;
            st_next.expired[1] = 1'b0;
        end else if (st_reg.cnt2 >= max2) begin
            st_next.expired[1] = 1'b1;
        end else if (ch_tick_in[1]) begin
            st_next.cnt2 = st_reg.cnt2 + `LHF_CNT_ONE;
        end
        if (tp) begin
            st_next.expired[1] = st_next.expired[0];
        end
        // Latch set wins over a same-cycle re-enable write
        for (int c = 0; c < 2; c++) begin
            if (channel_enable_write_in[c]) begin
                st_next.latch_off[c] = 1'b0;
            end
            if (lat_f[c]) begin
                st_next.latch_off[c] = 1'b1;
            end
        end
        st_next.fault_oe = any_f;
        st_next.chan_off = force_off | st_reg.latch_off
                         | st_reg.expired;
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '{mft_code: `LHF_RST_MFT, fen_a: `LHF_RST_FEN_A,
                        fen_b: `LHF_RST_FEN_B, latch_sel: `LHF_RST_LATCH,
                        ov_thr: `LHF_RST_OVTHR, trim: `LHF_RST_TRIM,
                        por: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state flops; open-drain pulls low only
    assign reg_rdata_out          = st_reg.rdata;
    assign fault_pin_out          = 2'h0;
    assign fault_pin_oe_out       = st_reg.fault_oe;
    assign channel_off_out        = st_reg.chan_off;
    assign timer_expired_out      = st_reg.expired;
    assign overvoltage_threshold_code_out = {st_reg.ov_thr[6:4],
                                             st_reg.ov_thr[2:0]};
    assign sense_offset_code_out  = {st_reg.trim[7:5], st_reg.trim[3:1]};
    assign power_on_indicator_out = st_reg.por;
    assign soft_reset_out         = st_reg.srst;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Checks
    a_srst_restores: assert property (wr_srst |=>
        st_reg.fen_a == `LHF_RST_FEN_A && st_reg.ov_thr == `LHF_RST_OVTHR)
        else $error("soft reset did not restore defaults");
    a_srst_keeps_por: assert property (wr_srst && !power_on_clear_in
        |=> st_reg.por == $past(st_reg.por))
        else $error("soft reset changed power-on indicator");
    a_srst_reads_zero: assert property (reg_rd_in &&
        reg_addr_in == `LHF_ADDR_SRST |=> reg_rdata_out == `LHF_ZERO8)
        else $error("soft reset register read nonzero");
    a_rsvd_zero: assert property (st_reg.fen_b[7:6] == 2'h0 &&
        st_reg.ov_thr[7] == 1'b0 && st_reg.ov_thr[3] == 1'b0)
        else $error("reserved bit set");
    a_lh_low_quiet: assert property (!limp_home_pin_in ##1
        !limp_home_pin_in |=> fault_pin_oe_out == 2'h0)
        else $error("fault pin active with limp-home low");
    a_force_off: assert property (st_reg.trim[`LHF_BIT_OFF1]
        |=> channel_off_out[0])
        else $error("force-off did not disable channel");
    a_latch_hold: assert property (lat_f[0] |=> st_reg.latch_off[0])
        else $error("latched fault did not shut channel");
    a_tp_timer2_idle: assert property (two_phase_select_in
        |=> st_reg.cnt2 == `LHF_MFT_C0)
        else $error("timer two ran in two-phase");
    a_timer_bound: assert property (st_reg.cnt1 <= `LHF_MFT_CF)
        else $error("timer one overran");
    a_tp_ch2_ovuv: assert property (two_phase_select_in |->
        uv_e[1] == 1'b0 && ov_e[1] == 1'b0)
        else $error("channel two OV/UV active in two-phase");

    c_srst: cover property (wr_srst ##1 soft_reset_out);
    c_expire: cover property (timer_expired_out[0]);
    c_latch: cover property (lat_f[1] ##[1:8] channel_enable_write_in[1]);

endmodule : lhf_regs
`default_nettype wire
